// [src/smbcf_map.svh]
// register map and timing constants of the bus configuration block
`ifndef SMBCF_MAP_SVH
`define SMBCF_MAP_SVH
`define SMBCF_BUS_CONFIG_ADDR 8'hC1
`define SMBCF_BUS_CONFIG_RESET 8'h00
`define SMBCF_IFACE_ENABLE_BIT 7
`define SMBCF_SLAVE_INHIBIT_BIT 6
`define SMBCF_BUSY_BIT 5
`define SMBCF_SDA_TIMING_EXTEND_BIT 4
`define SMBCF_CLOCK_LOW_TIMEOUT_ENABLE_BIT 3
`define SMBCF_BUS_FREE_TIMEOUT_ENABLE_BIT 2
`define SMBCF_SRC_SEL_MSB 1
`define SMBCF_SRC_SEL_LSB 0
`define SMBCF_FREE_PERIODS 10
`endif

// [src/smbcf_pkg.sv]
// types shared by the bus configuration block
package smbcf_pkg;
  typedef enum logic [1:0] {
    SMBCF_SRC_T0 = 2'b00,
    SMBCF_SRC_T1 = 2'b01,
    SMBCF_SRC_T2HI = 2'b10,
    SMBCF_SRC_T2LO = 2'b11
  } smbcf_src_type;
endpackage

// [src/smbus_config_timeout.sv]
// configuration register, bus supervision and timeouts of the two-wire interface
// Functional notes
// - With the enable bit set the interface is active and watches both lines, else it is idle.
// - While slave inhibit is in force no slave event interrupt is raised.
// - Slave inhibit never affects master interrupts.
// - The read-only busy bit is set by hardware while a transfer is in progress.
// - Busy is cleared on a STOP or when the bus-free timeout expires.
// - The extension bit selects normal (0) or extended (1) SDA setup and hold timing.
// - With clock-low timeout enabled the third timer counts once the clock goes low.
// - In split mode only the third timer's high byte is held in reload while the clock is high.
// - With free timeout enabled the bus is free after both lines stay high over 10 source periods.
// - The source field picks timer 0, timer 1, timer 2 high byte or timer 2 low byte overflow.
// - While inhibited the lines are still watched, addresses are refused and no slave irq is raised.
// - A new slave inhibit takes effect only from the next START.
// - A master START waiting for the bus is issued right after the free timeout.
`timescale 1ns/100ps
`include "smbcf_map.svh"

module smbus_config_timeout #(
  parameter int FREE_PERIODS = `SMBCF_FREE_PERIODS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic timer0Ovf,
  input wire logic timer1Ovf,
  input wire logic timer2HiOvf,
  input wire logic timer2LoOvf,
  input wire logic timer3Split,
  input wire logic slaveEvent,
  input wire logic masterEvent,
  input wire logic addrReceived,
  input wire logic startPending,
  output logic ifaceEnable,
  output logic sdaTimingExtend,
  output logic bitRateTick,
  output logic timer3ReloadHigh,
  output logic timer3ReloadLow,
  output logic slaveIrq,
  output logic masterIrq,
  output logic addrNack,
  output logic busBusy,
  output logic busFree,
  output logic startIssue
);

  if (FREE_PERIODS < 1 || FREE_PERIODS > 254) begin : gBadFreePeriods
    $error("FREE_PERIODS must lie in 1..254");
  end

  localparam logic [7:0] FREE_LIMIT = 8'(FREE_PERIODS + 1);

  function automatic logic startSeen(input logic scl, input logic sda, input logic sdaOld);
    startSeen = scl && sdaOld && !sda;
  endfunction

  function automatic logic stopSeen(input logic scl, input logic sda, input logic sdaOld);
    stopSeen = scl && !sdaOld && sda;
  endfunction

  // shared by the write and the read path so both decode the same address
  function automatic logic cfgHit(input logic [7:0] addr);
    cfgHit = addr == `SMBCF_BUS_CONFIG_ADDR;
  endfunction

  logic [7:0] config_reg;
  logic sclMeta_reg;
  logic sdaMeta_reg;
  logic sclSync_reg;
  logic sdaSync_reg;
  logic sdaOld_reg;
  logic busy_reg;
  logic inhibitActive_reg;
  logic [7:0] freeCount_reg;
  logic [7:0] freeCount_next;
  logic sourceTick;
  logic startDet;
  logic stopDet;
  logic freeExpire;
  logic enabled;
  smbcf_pkg::smbcf_src_type srcSel;

  assign enabled = config_reg[`SMBCF_IFACE_ENABLE_BIT];
  assign srcSel = smbcf_pkg::smbcf_src_type'(config_reg[`SMBCF_SRC_SEL_MSB:`SMBCF_SRC_SEL_LSB]);

  // software access; the busy bit is not writable
  always_ff @(posedge clock) begin
    if (rst) begin
      config_reg <= `SMBCF_BUS_CONFIG_RESET;
    end else if (sfrWrite && cfgHit(sfrAddr)) begin
      config_reg <= sfrWdata;
      config_reg[`SMBCF_BUSY_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead && cfgHit(sfrAddr)) begin
      sfrRdata <= config_reg;
      sfrRdata[`SMBCF_BUSY_BIT] <= busy_reg;
    end else begin
      sfrRdata <= 8'h00;
    end
  end

  // pin synchronisers; open-drain lines idle high
  always_ff @(posedge clock) begin
    if (rst) begin
      sclMeta_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaOld_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sdaMeta_reg <= sdaIn;
      sclSync_reg <= sclMeta_reg;
      sdaSync_reg <= sdaMeta_reg;
      sdaOld_reg <= sdaSync_reg;
    end
  end

  // the line watch runs only while the interface is enabled
  assign startDet = enabled && startSeen(sclSync_reg, sdaSync_reg, sdaOld_reg);
  assign stopDet = enabled && stopSeen(sclSync_reg, sdaSync_reg, sdaOld_reg);

  always_comb begin
    unique case (srcSel)
      smbcf_pkg::SMBCF_SRC_T0: sourceTick = timer0Ovf;
      smbcf_pkg::SMBCF_SRC_T1: sourceTick = timer1Ovf;
      smbcf_pkg::SMBCF_SRC_T2HI: sourceTick = timer2HiOvf;
      smbcf_pkg::SMBCF_SRC_T2LO: sourceTick = timer2LoOvf;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bitRateTick <= 1'b0;
    end else begin
      bitRateTick <= enabled && sourceTick;
    end
  end

  // counts whole source periods with both lines high; saturates one past the limit
  always_comb begin
    freeCount_next = freeCount_reg;
    if (!enabled || !config_reg[`SMBCF_BUS_FREE_TIMEOUT_ENABLE_BIT]) begin
      freeCount_next = 8'h00;
    end else if (!sclSync_reg || !sdaSync_reg) begin
      freeCount_next = 8'h00;
    end else if (sourceTick && freeCount_reg < FREE_LIMIT) begin
      freeCount_next = freeCount_reg + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      freeCount_reg <= 8'h00;
    end else begin
      freeCount_reg <= freeCount_next;
    end
  end

  // more than the limit means the count has just reached limit plus one
  assign freeExpire = freeCount_next == FREE_LIMIT && freeCount_reg != FREE_LIMIT;

  always_ff @(posedge clock) begin
    if (rst) begin
      busFree <= 1'b0;
    end else begin
      busFree <= freeCount_next == FREE_LIMIT;
    end
  end

  // a START in the same cycle as a clear keeps the bus busy
  always_ff @(posedge clock) begin
    if (rst || !enabled) begin
      busy_reg <= 1'b0;
    end else if (startDet) begin
      busy_reg <= 1'b1;
    end else if (stopDet || freeExpire) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busBusy <= 1'b0;
    end else if (!enabled) begin
      busBusy <= 1'b0;
    end else if (startDet) begin
      busBusy <= 1'b1;
    end else if (stopDet || freeExpire) begin
      busBusy <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      startIssue <= 1'b0;
    end else begin
      startIssue <= freeExpire && startPending && enabled;
    end
  end

  // inhibit is sampled at each START so the running transfer keeps its interrupts
  always_ff @(posedge clock) begin
    if (rst || !enabled) begin
      inhibitActive_reg <= 1'b0;
    end else if (startDet) begin
      inhibitActive_reg <= config_reg[`SMBCF_SLAVE_INHIBIT_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      slaveIrq <= 1'b0;
      masterIrq <= 1'b0;
      addrNack <= 1'b0;
    end else begin
      slaveIrq <= enabled && slaveEvent && !inhibitActive_reg;
      masterIrq <= enabled && masterEvent;
      addrNack <= enabled && addrReceived && inhibitActive_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ifaceEnable <= 1'b0;
      sdaTimingExtend <= 1'b0;
    end else begin
      ifaceEnable <= enabled;
      sdaTimingExtend <= config_reg[`SMBCF_SDA_TIMING_EXTEND_BIT];
    end
  end

  // timer 3 reload follows the synchronised clock line; it counts while the clock is low
  always_ff @(posedge clock) begin
    if (rst) begin
      timer3ReloadHigh <= 1'b0;
      timer3ReloadLow <= 1'b0;
    end else if (enabled && config_reg[`SMBCF_CLOCK_LOW_TIMEOUT_ENABLE_BIT] && sclSync_reg) begin
      timer3ReloadHigh <= 1'b1;
      timer3ReloadLow <= !timer3Split;
    end else begin
      timer3ReloadHigh <= 1'b0;
      timer3ReloadLow <= 1'b0;
    end
  end

endmodule

// [test/smbcf_bus_party.sv]
// another bus party driving both lines; lines idle high by pull-up
`timescale 1ns/100ps
module smbcf_bus_party (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start_frame();
    sda = 1'b0;
    #40;
    scl = 1'b0;
    #40;
  endtask
  task automatic stop_frame();
    sda = 1'b0;
    #40;
    scl = 1'b1;
    #40;
    sda = 1'b1;
    #40;
  endtask
  // data rises while clock low, so no stop is seen
  task automatic release_lines();
    sda = 1'b1;
    #40;
    scl = 1'b1;
    #40;
  endtask
  task automatic clock_dip();
    scl = 1'b0;
    #40;
    scl = 1'b1;
    #40;
  endtask
endmodule

// [test/smbcf_chk.sv]
// port assertions for the bus configuration block
`timescale 1ns/100ps
module smbcf_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic sfrRead,
  input wire logic [7:0] sfrRdata,
  input wire logic timer0Ovf,
  input wire logic timer1Ovf,
  input wire logic timer2HiOvf,
  input wire logic timer2LoOvf,
  input wire logic slaveEvent,
  input wire logic masterEvent,
  input wire logic addrReceived,
  input wire logic ifaceEnable,
  input wire logic bitRateTick,
  input wire logic timer3ReloadHigh,
  input wire logic timer3ReloadLow,
  input wire logic slaveIrq,
  input wire logic masterIrq,
  input wire logic addrNack,
  input wire logic busBusy,
  input wire logic busFree,
  input wire logic startIssue
);
  logic anyOvf;
  assign anyOvf = timer0Ovf | timer1Ovf | timer2HiOvf | timer2LoOvf;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_master; masterEvent ##1 ifaceEnable |-> masterIrq; endproperty
  a_master: assert property (p_master) else $error("master irq missing");
  property p_slave; slaveIrq |-> $past(slaveEvent); endproperty
  a_slave: assert property (p_slave) else $error("slave irq uncaused");
  property p_nack; addrNack |-> $past(addrReceived); endproperty
  a_nack: assert property (p_nack) else $error("nack uncaused");
  property p_tick; bitRateTick |-> $past(anyOvf) && ifaceEnable; endproperty
  a_tick: assert property (p_tick) else $error("tick uncaused");
  property p_rdata; sfrRdata != 8'h00 |-> $past(sfrRead); endproperty
  a_rdata: assert property (p_rdata) else $error("read data unasked");
  property p_split; timer3ReloadLow |-> timer3ReloadHigh; endproperty
  a_split: assert property (p_split) else $error("low reload alone");
  property p_issue; startIssue |-> $rose(busFree); endproperty
  a_issue: assert property (p_issue) else $error("start not at expiry");
  property p_free; $rose(busFree) |-> ##[0:1] !busBusy; endproperty
  a_free: assert property (p_free) else $error("busy kept at expiry");
  property p_busy; $rose(busBusy) |-> ifaceEnable; endproperty
  a_busy: assert property (p_busy) else $error("busy while disabled");
endmodule
bind smbus_config_timeout smbcf_chk smbcf_chk_inst (.*);

// [test/tb_smbus_config_timeout.sv]
// self-checking bench for the bus configuration block
`timescale 1ns/100ps
module tb_smbus_config_timeout;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWdata = 8'h00;
  logic sfrWrite = 1'b0;
  logic sfrRead = 1'b0;
  logic [3:0] ovf = 4'h0;
  logic [2:0] evt = 3'h0;
  logic split = 1'b0;
  logic startPending = 1'b0;
  logic issued = 1'b0;
  logic [7:0] sfrRdata;
  logic sclIn, sdaIn, ifaceEnable, sdaTimingExtend, bitRateTick, timer3ReloadHigh;
  logic timer3ReloadLow, slaveIrq, masterIrq, addrNack, busBusy, busFree, startIssue;
  int error_cnt = 0;
  int total_checks = 0;
  always #2 clock = ~clock;
  always @(posedge clock) if (startIssue === 1'b1) issued <= 1'b1;
  smbcf_bus_party smbcf_bus_party_inst (.scl(sclIn), .sda(sdaIn));
  smbus_config_timeout #(.FREE_PERIODS(2)) smbus_config_timeout_inst (
    .clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sclIn(sclIn), .sdaIn(sdaIn),
    .timer0Ovf(ovf[0]), .timer1Ovf(ovf[1]), .timer2HiOvf(ovf[2]), .timer2LoOvf(ovf[3]),
    .timer3Split(split), .slaveEvent(evt[2]), .masterEvent(evt[1]), .addrReceived(evt[0]),
    .startPending(startPending), .ifaceEnable(ifaceEnable), .sdaTimingExtend(sdaTimingExtend),
    .bitRateTick(bitRateTick), .timer3ReloadHigh(timer3ReloadHigh),
    .timer3ReloadLow(timer3ReloadLow), .slaveIrq(slaveIrq), .masterIrq(masterIrq),
    .addrNack(addrNack), .busBusy(busBusy), .busFree(busFree), .startIssue(startIssue));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] d);
    @(negedge clock);
    sfrAddr = addr;
    sfrWdata = d;
    sfrWrite = wr;
    sfrRead = !wr;
    @(negedge clock);
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    access(1'b0, addr, 8'h00);
    check(sfrRdata, exp);
  endtask
  // outputs are {bitRateTick, slaveIrq, masterIrq, addrNack}, one cycle after the pulse
  task automatic pulse(input logic [3:0] o, input logic [2:0] e, input logic [3:0] exp);
    @(negedge clock);
    ovf = o;
    evt = e;
    @(negedge clock);
    ovf = 4'h0;
    evt = 3'h0;
    check({4'h0, bitRateTick, slaveIrq, masterIrq, addrNack}, {4'h0, exp});
    repeat (4) @(negedge clock);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    rd(8'hC1, 8'h00);
    rd(8'hC2, 8'h00);
    access(1'b1, 8'hC1, 8'hFF);
    rd(8'hC1, 8'hDF);
    access(1'b1, 8'hC2, 8'h00);
    rd(8'hC1, 8'hDF);
    check(ifaceEnable, 8'h01);
    check(sdaTimingExtend, 8'h01);
    access(1'b1, 8'hC1, 8'h00);
    pulse(4'h0, 3'h0, 4'h0);
    check({ifaceEnable, sdaTimingExtend}, 8'h00);
    $display("test 1 done");
    access(1'b1, 8'hC1, 8'h88);
    pulse(4'h0, 3'h0, 4'h0);
    check({timer3ReloadHigh, timer3ReloadLow}, 8'h03);
    split = 1'b1;
    pulse(4'h0, 3'h0, 4'h0);
    check({timer3ReloadHigh, timer3ReloadLow}, 8'h02);
    smbcf_bus_party_inst.start_frame();
    rd(8'hC1, 8'hA8);
    check(busBusy, 8'h01);
    check(timer3ReloadHigh, 8'h00);
    smbcf_bus_party_inst.stop_frame();
    rd(8'hC1, 8'h88);
    check(busBusy, 8'h00);
    // clock stuck low: the timeout handler turns the interface off and on again
    smbcf_bus_party_inst.start_frame();
    access(1'b1, 8'hC1, 8'h08);
    rd(8'hC1, 8'h08);
    check(busBusy, 8'h00);
    access(1'b1, 8'hC1, 8'h88);
    smbcf_bus_party_inst.stop_frame();
    rd(8'hC1, 8'h88);
    $display("test 2 done");
    for (int s = 0; s < 4; s++) begin
      access(1'b1, 8'hC1, {6'h20, 2'(s)});
      pulse(~(4'h1 << s), 3'h0, 4'h0);
      pulse(4'h1 << s, 3'h0, 4'h8);
    end
    $display("test 3 done");
    access(1'b1, 8'hC1, 8'hC0);
    pulse(4'h0, 3'h4, 4'h4);
    pulse(4'h0, 3'h1, 4'h0);
    smbcf_bus_party_inst.start_frame();
    rd(8'hC1, 8'hE0);
    pulse(4'h0, 3'h7, 4'h3);
    smbcf_bus_party_inst.stop_frame();
    $display("test 4 done");
    access(1'b1, 8'hC1, 8'h84);
    smbcf_bus_party_inst.start_frame();
    smbcf_bus_party_inst.release_lines();
    startPending = 1'b1;
    rd(8'hC1, 8'hA4);
    check(busBusy, 8'h01);
    for (int i = 0; i < 5; i++) begin
      if (i == 2) smbcf_bus_party_inst.clock_dip();
      pulse(4'h1, 3'h0, 4'h8);
      check(busFree, {7'h00, i == 4});
    end
    check(issued, 8'h01);
    check(busBusy, 8'h00);
    rd(8'hC1, 8'h84);
    $display("test 5 done");
    tally_and_finish();
  end
endmodule
